// *** verilog/msoc_pkg.sv ***
package msoc_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] OFF_CTRL_A   = 8'h00;
    localparam logic [7:0] OFF_CTRL_B   = 8'h04;
    localparam logic [7:0] OFF_CTRL_C   = 8'h08;
    localparam logic [7:0] OFF_PHASE    = 8'h0c;
    localparam logic [7:0] OFF_WEIGHT   = 8'h10;
    localparam logic [7:0] OFF_DELAY    = 8'h14;
    localparam logic [7:0] OFF_CONFIG   = 8'h18;
    localparam logic [7:0] OFF_STATUS   = 8'h1c;
    localparam logic [7:0] OFF_POLARITY = 8'h20;

    // motor_control_a fields
    localparam int A_MOE = 7;
    localparam int A_SR  = 5;
    localparam int A_DAC = 4;
    localparam int A_PZ  = 1;
    localparam int A_DCB = 0;
    // motor_control_b fields
    localparam int B_RSV = 7;
    localparam int B_CPB = 6;
    localparam int B_HDM = 5;
    localparam int B_SDM = 4;
    localparam int B_OCV = 3;
    localparam int B_OS2 = 2;
    localparam int B_OS1 = 1;
    localparam int B_OS0 = 0;
    localparam logic [7:0] B_PRE_MASK = 8'h74;
    // motor_control_c, config and status fields
    localparam int C_FLAG   = 7;
    localparam int CFG_TES  = 6;
    localparam int CFG_ZEF  = 2;
    localparam int CFG_CURRENT_LIMIT_IRQ_ENABLE = 0;
    localparam int ST_CLI   = 7;
    localparam int CH_N     = 6;

    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [1:0] TES_TIMER  = 2'h0;
    localparam logic [3:0] ZEF_NONE   = 4'h0;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // which span of the step is running, one-hot
    typedef enum logic [2:0] {
        STEP_CD = 3'h1,
        STEP_DZ = 3'h2,
        STEP_ZC = 3'h4
    } msoc_step_t;

    // sticky flag, software writes 0 to clear, a set in the same cycle wins
    function automatic logic msoc_flag(input logic cur, input logic set,
                                       input logic clr);
        msoc_flag = set | (cur & ~clr);
    endfunction
endpackage

// *** verilog/msoc_delay_mult.sv ***
`timescale 1ns/1ps
`default_nettype none
// weight times capture over 256, result registered
module msoc_delay_mult (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] weight,
    input  wire logic [7:0] capture,
    output logic      [7:0] delay_r
);
    import msoc_pkg::*;

    logic [15:0] prod;

    // dividing by 256 is just the upper byte of the product
    assign prod = weight * capture;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            delay_r <= RST_BYTE;
        end else begin
            delay_r <= prod[15:8];
        end
    end

    delay_prod_a: assert property (@(posedge aclk) disable iff (!aresetn)
        1'b1 |=> delay_r == 8'((16'($past(weight)) * 16'($past(capture))) >> 8))
        else $error("commutation delay product wrong");
endmodule
`default_nettype wire

// *** verilog/msoc_top.sv ***
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module msoc_top #(
    parameter logic [5:0] RST_OE  = 6'h00,
    parameter logic [5:0] RST_LVL = 6'h00
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] s_axi_awaddr,
    input  wire logic       s_axi_awvalid,
    output logic            s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0] s_axi_wstrb,
    input  wire logic       s_axi_wvalid,
    output logic            s_axi_wready,
    output logic      [1:0] s_axi_bresp,
    output logic            s_axi_bvalid,
    input  wire logic       s_axi_bready,
    input  wire logic [7:0] s_axi_araddr,
    input  wire logic       s_axi_arvalid,
    output logic            s_axi_arready,
    output logic      [31:0] s_axi_rdata,
    output logic      [1:0] s_axi_rresp,
    output logic            s_axi_rvalid,
    input  wire logic       s_axi_rready,
    input  wire logic       hw_comm_evt,
    input  wire logic       hw_demag_evt,
    input  wire logic       sim_demag_evt,
    input  wire logic       zc_rise_evt,
    input  wire logic       zc_fall_evt,
    input  wire logic [7:0] motor_timer,
    input  wire logic       timer_ovf_evt,
    input  wire logic       speed_err_evt,
    input  wire logic       current_limit_evt,
    input  wire logic       pwm_in,
    output logic      [5:0] phase_outputs,
    output logic      [5:0] phase_outputs_oe,
    output logic            comm_evt_out,
    output logic            current_limit_irq,
    output logic            pwm_cut,
    output logic      [3:0] zero_event_filter_eff
);
    import msoc_pkg::*;
    logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, b_act_r, ctrl_c_r, ctrl_c_nxt;
    logic [7:0] phase_r, weight_r, delay_r, config_r, polarity_r;
    logic [7:0] prev_zc_r, last_zc_r, mult_q, rd_byte;
    logic [5:0] chan_r, lvl;
    logic       cli_r, z_d1_r, z_d2_r;
    logic       aw_got_r, w_got_r;
    logic [7:0] awaddr_r, wbyte_r;
    logic       wstrb0_r;
    msoc_step_t step_r, step_nxt;
    // bus handshakes: address and data may arrive in either order
    logic aw_hs, w_hs, ar_hs, wr_do, b_done, r_done, aw_got_nxt, w_got_nxt;
    logic bvalid_nxt, rvalid_nxt, wr_hit, rd_hit;
    assign aw_hs      = s_axi_awvalid & s_axi_awready;
    assign w_hs       = s_axi_wvalid & s_axi_wready;
    assign ar_hs      = s_axi_arvalid & s_axi_arready;
    assign wr_do      = aw_got_r & w_got_r & ~s_axi_bvalid;
    assign b_done     = s_axi_bvalid & s_axi_bready;
    assign r_done     = s_axi_rvalid & s_axi_rready;
    assign aw_got_nxt = aw_hs | (aw_got_r & ~wr_do);
    assign w_got_nxt  = w_hs | (w_got_r & ~wr_do);
    assign bvalid_nxt = wr_do | (s_axi_bvalid & ~b_done);
    assign rvalid_nxt = ar_hs | (s_axi_rvalid & ~r_done);

    // write decode, byte lane 0 carries every register
    logic wr_a, wr_b, wr_c, wr_ph, wr_wt, wr_dl, wr_cfg, wr_st, wr_pol;
    assign wr_a   = wr_do & wstrb0_r & (awaddr_r == OFF_CTRL_A);
    assign wr_b   = wr_do & wstrb0_r & (awaddr_r == OFF_CTRL_B);
    assign wr_c   = wr_do & wstrb0_r & (awaddr_r == OFF_CTRL_C);
    assign wr_ph  = wr_do & wstrb0_r & (awaddr_r == OFF_PHASE);
    assign wr_wt  = wr_do & wstrb0_r & (awaddr_r == OFF_WEIGHT);
    assign wr_dl  = wr_do & wstrb0_r & (awaddr_r == OFF_DELAY);
    assign wr_cfg = wr_do & wstrb0_r & (awaddr_r == OFF_CONFIG);
    assign wr_st  = wr_do & wstrb0_r & (awaddr_r == OFF_STATUS);
    assign wr_pol = wr_do & wstrb0_r & (awaddr_r == OFF_POLARITY);
    assign wr_hit = wr_a | wr_b | wr_c | wr_ph | wr_wt | wr_dl | wr_cfg | wr_st | wr_pol
                    | (~wstrb0_r & (awaddr_r <= OFF_POLARITY) & (awaddr_r[1:0] == 2'h0));

    // control bits, immediate and preloaded
    logic dac, sr, pz, dcb, output_enable_bit, current_limit_irq_enable, voltage_overcurrent_handling, cpb_act, hdm_act, sdm_act;
    logic [1:0] tes;
    assign output_enable_bit     = ctrl_a_r[A_MOE];
    assign sr      = ctrl_a_r[A_SR];
    assign dac     = ctrl_a_r[A_DAC];
    assign pz      = ctrl_a_r[A_PZ];
    assign dcb     = ctrl_a_r[A_DCB];
    assign voltage_overcurrent_handling     = ctrl_b_r[B_OCV];
    assign cpb_act = b_act_r[B_CPB];
    assign hdm_act = b_act_r[B_HDM];
    assign sdm_act = b_act_r[B_SDM];
    assign current_limit_irq_enable    = config_r[CFG_CURRENT_LIMIT_IRQ_ENABLE];
    assign tes     = config_r[CFG_TES +: 2];
    // commutation: hardware in normal running, any phase write in direct access
    logic c_evt;
    assign c_evt = dac ? wr_ph : hw_comm_evt;
    // demag and zero events, masks and edge taken from the active copy
    logic d_evt, z_edge, z_evt;
    assign d_evt  = (hw_demag_evt & hdm_act) | (sim_demag_evt & sdm_act);
    assign z_edge = cpb_act ? zc_rise_evt : zc_fall_evt;
    assign z_evt  = z_edge & ~c_evt & (step_r != STEP_ZC);
    // step tracking; a zero before demag is ignored in sensorless mode
    always_comb begin
        step_nxt = step_r;
        case (step_r)
            STEP_CD: begin
                if (sr & z_evt) begin
                    step_nxt = STEP_ZC;
                end else if (~sr & d_evt) begin
                    step_nxt = STEP_DZ;
                end
            end
            STEP_DZ: begin
                if (z_evt) begin
                    step_nxt = STEP_ZC;
                end
            end
            STEP_ZC: step_nxt = step_r;
            default: step_nxt = STEP_CD;
        endcase
        if (c_evt) begin
            step_nxt = STEP_CD;
        end
    end

    logic z_taken;
    assign z_taken = z_evt & ((step_r == STEP_DZ) | (sr & (step_r == STEP_CD)));
    // side select: top bit preloaded, lower two live
    logic pwm_low, span_low;
    assign span_low = (step_r == STEP_CD) ? b_act_r[B_OS2] :
                      (step_r == STEP_DZ) ? ctrl_b_r[B_OS1] : ctrl_b_r[B_OS0];
    assign pwm_low  = dac ? ctrl_b_r[B_OS0] : span_low;

    // current loop cut and voltage-mode trip
    logic trip;
    assign trip = current_limit_irq_enable & cli_r & voltage_overcurrent_handling;
    // output level per channel, odd channels are high side
    always_comb begin
        for (int i = 0; i < CH_N; i++) begin
            lvl[i] = chan_r[i] & ((i[0] == pwm_low) | (pwm_in & ~cli_r));
        end
    end

    // register A: hardware trip drops the output enable and beats a write
    always_comb begin
        ctrl_a_nxt = wr_a ? wbyte_r : ctrl_a_r;
        if (trip) begin
            ctrl_a_nxt[A_MOE] = 1'b0;
        end
    end

    // register C flag source follows the speed sensor selection
    logic flag_src;
    assign flag_src = (tes == TES_TIMER) ? timer_ovf_evt : speed_err_evt;
    always_comb begin
        ctrl_c_nxt = wr_c ? wbyte_r : ctrl_c_r;
        ctrl_c_nxt[C_FLAG] = msoc_flag(ctrl_c_r[C_FLAG], flag_src,
                                       wr_c & ~wbyte_r[C_FLAG]);
    end

    // read mux; status shows live flag, step and active channels
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = RST_BYTE;
        case (s_axi_araddr)
            OFF_CTRL_A:   rd_byte = ctrl_a_r;
            OFF_CTRL_B:   rd_byte = ctrl_b_r;
            OFF_CTRL_C:   rd_byte = ctrl_c_r;
            OFF_PHASE:    rd_byte = phase_r;
            OFF_WEIGHT:   rd_byte = weight_r;
            OFF_DELAY:    rd_byte = delay_r;
            OFF_CONFIG:   rd_byte = config_r;
            OFF_STATUS:   rd_byte = {cli_r, (step_r == STEP_ZC), chan_r};
            OFF_POLARITY: rd_byte = polarity_r;
            default:      rd_hit = 1'b0;
        endcase
    end

    msoc_delay_mult u_mult (
        .aclk    (aclk),
        .aresetn (aresetn),
        .weight  (weight_r),
        .capture (dcb ? last_zc_r : prev_zc_r),
        .delay_r (mult_q)
    );
    // bus slave state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= RST_BYTE;
            wbyte_r       <= RST_BYTE;
            wstrb0_r      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rresp   <= RESP_OKAY;
            s_axi_rdata   <= 32'h0;
        end else begin
            aw_got_r      <= aw_got_nxt;
            w_got_r       <= w_got_nxt;
            s_axi_awready <= ~aw_got_nxt & ~bvalid_nxt;
            s_axi_wready  <= ~w_got_nxt & ~bvalid_nxt;
            s_axi_bvalid  <= bvalid_nxt;
            s_axi_arready <= ~rvalid_nxt;
            s_axi_rvalid  <= rvalid_nxt;
            if (aw_hs) begin
                awaddr_r <= s_axi_awaddr;
            end
            if (w_hs) begin
                wbyte_r  <= s_axi_wdata[7:0];
                wstrb0_r <= s_axi_wstrb[0];
            end
            if (wr_do) begin
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
            if (ar_hs) begin
                s_axi_rdata <= {24'h0, rd_byte};
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // registers; preload copies move only on a commutation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_a_r   <= RST_BYTE;
            ctrl_b_r   <= RST_BYTE;
            b_act_r    <= RST_BYTE;
            ctrl_c_r   <= RST_BYTE;
            phase_r    <= RST_BYTE;
            chan_r     <= RST_BYTE[5:0];
            weight_r   <= RST_BYTE;
            config_r   <= RST_BYTE;
            polarity_r <= RST_BYTE;
            cli_r      <= 1'b0;
        end else begin
            ctrl_a_r <= ctrl_a_nxt;
            ctrl_c_r <= ctrl_c_nxt;
            cli_r    <= msoc_flag(cli_r, current_limit_evt, wr_st & ~wbyte_r[ST_CLI]);
            if (wr_b) begin
                ctrl_b_r <= wbyte_r & ~(8'h01 << B_RSV);
            end
            if (wr_ph) begin
                phase_r <= wbyte_r;
            end
            if (c_evt) begin
                b_act_r <= (wr_b ? wbyte_r : ctrl_b_r) & B_PRE_MASK;
                chan_r  <= wr_ph ? wbyte_r[5:0] : phase_r[5:0];
            end
            if (wr_wt) begin
                weight_r <= wbyte_r;
            end
            if (wr_cfg) begin
                config_r <= wbyte_r;
            end
            if (wr_pol) begin
                polarity_r <= wbyte_r;
            end
        end
    end

    // zero captures and commutation delay; product lands in delay_r three cycles after z
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prev_zc_r <= RST_BYTE;
            last_zc_r <= RST_BYTE;
            delay_r   <= RST_BYTE;
            z_d1_r    <= 1'b0;
            z_d2_r    <= 1'b0;
            step_r    <= STEP_CD;
        end else begin
            z_d1_r <= z_taken;
            z_d2_r <= z_d1_r;
            step_r <= step_nxt;
            if (z_taken) begin
                prev_zc_r <= last_zc_r;
                last_zc_r <= motor_timer;
            end
            if (z_d2_r) begin
                delay_r <= mult_q;
            end else if (wr_dl) begin
                delay_r <= wbyte_r;
            end
        end
    end

    // pins; every output is a flop, one cycle behind its cause
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_outputs         <= RST_LVL;
            phase_outputs_oe      <= RST_OE;
            comm_evt_out          <= 1'b0;
            current_limit_irq     <= 1'b0;
            pwm_cut               <= 1'b0;
            zero_event_filter_eff <= ZEF_NONE;
        end else begin
            phase_outputs         <= output_enable_bit ? (lvl ^ polarity_r[5:0]) : RST_LVL;
            phase_outputs_oe      <= output_enable_bit ? 6'h3f : RST_OE;
            comm_evt_out          <= c_evt;
            current_limit_irq     <= current_limit_irq_enable & cli_r;
            pwm_cut               <= cli_r & ~trip;
            zero_event_filter_eff <= pz ? ZEF_NONE : config_r[CFG_ZEF +: 4];
        end
    end

    // the event pulse leaves the same edge that loads the channels
    dac_phase_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dac && wr_ph |=> chan_r == $past(wbyte_r[5:0]) && comm_evt_out)
        else $error("direct phase write not applied");
    pend_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !dac && !hw_comm_evt |=> $stable(chan_r) && $stable(b_act_r))
        else $error("pending value applied without commutation");
    dac_side_a: assert property (@(posedge aclk) disable iff (!aresetn)
        dac |-> pwm_low == ctrl_b_r[B_OS0])
        else $error("direct access side not from lowest bit");
    moe_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !output_enable_bit |=> phase_outputs_oe == RST_OE && phase_outputs == RST_LVL)
        else $error("outputs not in reset state");
    pz_filter_a: assert property (@(posedge aclk) disable iff (!aresetn)
        pz |=> zero_event_filter_eff == ZEF_NONE)
        else $error("filter count not ignored");
    ocv_trip_a: assert property (@(posedge aclk) disable iff (!aresetn)
        trip |=> !output_enable_bit && current_limit_irq ##1 phase_outputs_oe == RST_OE)
        else $error("voltage over-current trip missed");
    cut_noirq_a: assert property (@(posedge aclk) disable iff (!aresetn)
        cli_r && !current_limit_irq_enable |=> pwm_cut && !current_limit_irq)
        else $error("current cut without enable wrong");
    c_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
        flag_src |=> ctrl_c_r[C_FLAG])
        else $error("register C flag not set");
    step_order_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !sr && step_r == STEP_CD && !c_evt |=> step_r != STEP_ZC)
        else $error("zero taken before demag");
endmodule
`default_nettype wire

// *** verilog/msoc_placeholder_none.sv ***
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// *** tb/msoc_inverter_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// three inverter legs; odd channel drives the high switch, even the low one
module msoc_inverter_model (
    input  wire logic       aclk,
    input  wire logic [5:0] phase_outputs,
    input  wire logic [5:0] phase_outputs_oe,
    output logic      [2:0] leg_v,
    output logic            shoot
);
    wire [5:0] sw_on;
    assign sw_on = phase_outputs & phase_outputs_oe;
    initial begin
        shoot = 1'b0;
        leg_v = 3'h0;
    end
    // a floating leg shows the inverse of its last level, never a settled guess
    always @(posedge aclk) begin
        for (int k = 0; k < 3; k++) begin
            if (sw_on[2*k+1] && sw_on[2*k]) shoot <= 1'b1;
            else if (sw_on[2*k+1]) leg_v[k] <= 1'b1;
            else if (sw_on[2*k]) leg_v[k] <= 1'b0;
            else leg_v[k] <= ~leg_v[k];
        end
    end
endmodule
`default_nettype wire

// *** tb/msoc_top_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module msoc_top_bench;
    import msoc_pkg::*;
    localparam logic [5:0] ROE = 6'h0a;
    localparam logic [5:0] RLV = 6'h15;
    localparam int CM = 0, HD = 1, SD = 2, ZR = 3, ZF = 4, OV = 5, SE = 6, CL = 7;
    logic        aclk, aresetn = 1'b0, pwm = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, mt = 8'h00, ev = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0, seed = 32'hd249265e, rd;
    logic [1:0]  rs;
    logic [7:0]  w, t2;
    logic [5:0]  p;
    logic        current_limit_irq_enable, voltage_overcurrent_handling, trip;
    wire         awready, wready, bvalid, arready, rvalid, cev, irq, cut, shoot;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [5:0]   po, oe;
    wire [3:0]   zef_eff;
    wire [2:0]   leg;
    int          bad_count = 0, n_checks = 0, ncev = 0, cyc = 0, n0;

    msoc_top #(.RST_OE(ROE), .RST_LVL(RLV)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .hw_comm_evt(ev[CM]), .hw_demag_evt(ev[HD]), .sim_demag_evt(ev[SD]),
        .zc_rise_evt(ev[ZR]), .zc_fall_evt(ev[ZF]), .motor_timer(mt),
        .timer_ovf_evt(ev[OV]), .speed_err_evt(ev[SE]), .current_limit_evt(ev[CL]),
        .pwm_in(pwm), .phase_outputs(po), .phase_outputs_oe(oe), .comm_evt_out(cev),
        .current_limit_irq(irq), .pwm_cut(cut), .zero_event_filter_eff(zef_eff));
    msoc_inverter_model i_inv (.aclk(aclk), .phase_outputs(po), .phase_outputs_oe(oe),
        .leg_v(leg), .shoot(shoot));

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    // watchdog and commutation pulse counter
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cev === 1'b1) ncev <= ncev + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    function automatic logic [7:0] dly(input logic [7:0] wt, input logic [7:0] c);
        dly = 8'((16'(wt) * 16'(c)) >> 8);
    endfunction
    // one switch per leg, so the stage never shorts
    function automatic logic [5:0] safe(input logic [31:0] r);
        safe = (r[5:0] & 6'h2a) | ((~r[5:0] >> 1) & 6'h15);
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            $display("BAD %s exp %h got %h", n, e, s);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        rs = bresp;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd = rdata;
        rs = rresp;
    endtask
    task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] e);
        rdr(a);
        chk(n, {24'h0, e}, rd);
    endtask
    // one-cycle event pulse, timer value presented with it
    task automatic pls(input int i, input logic [7:0] tv);
        @(posedge aclk);
        ev[i] <= 1'b1;
        mt <= tv;
        @(posedge aclk);
        ev[i] <= 1'b0;
        repeat (2) @(posedge aclk);
    endtask
    task automatic st();
        repeat (3) @(posedge aclk);
    endtask
    task automatic end_sim();
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        st();
        chk("oe_rst", ROE, oe);
        chk("po_rst", RLV, po);
        rchk("ctrl_a", OFF_CTRL_A, 8'h00);
        rchk("ctrl_b", OFF_CTRL_B, 8'h00);
        rchk("ctrl_c", OFF_CTRL_C, 8'h00);
        // unmapped place answers with an error and reads zero
        wr(8'h40, 8'hff);
        chk("bresp", RESP_SLVERR, rs);
        rdr(8'h40);
        chk("rresp", RESP_SLVERR, rs);
        chk("rdata", 32'h0, rd);
        for (int s = 0; s < 2; s++) begin
            seed = xs(seed);
            wr(OFF_CTRL_A, 8'(s << 2));
            wr(OFF_DELAY, seed[7:0]);
            rchk("delay_rw", OFF_DELAY, seed[7:0]);
            rchk("swa", OFF_CTRL_A, 8'(s << 2));
        end
        seed = xs(seed);
        wr(OFF_CONFIG, {2'h0, seed[3:0], 2'h0});
        st();
        chk("zef", seed[3:0], zef_eff);
        wr(OFF_CTRL_A, 8'h02);
        st();
        chk("zef_pz", 32'h0, zef_eff);
        wr(OFF_CTRL_A, 8'h80);
        st();
        chk("oe_on", 32'h3f, oe);
        // channel bits wait for a commutation without direct access
        seed = xs(seed);
        p = safe(seed);
        wr(OFF_PHASE, {2'h0, p});
        rdr(OFF_STATUS);
        chk("ch_pend", 32'h0, rd[5:0]);
        pls(CM, 8'h00);
        rdr(OFF_STATUS);
        chk("ch_comm", p, rd[5:0]);
        wr(OFF_CTRL_A, 8'h90);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            p = safe(seed);
            wr(OFF_CTRL_B, {5'h0, seed[10:8]});
            n0 = ncev;
            wr(OFF_PHASE, {2'h0, p});
            st();
            chk("comm_evt", n0 + 1, ncev);
            rdr(OFF_STATUS);
            chk("ch_dir", p, rd[5:0]);
            chk("pwm_side", seed[8] ? p & 6'h2a : p & 6'h15, po);
        end
        // sensors: edge select moves at commutation, delay from chosen capture
        seed = xs(seed);
        w = seed[7:0];
        t2 = seed[15:8];
        wr(OFF_CTRL_B, 8'h00);
        wr(OFF_CTRL_A, 8'ha0);
        wr(OFF_WEIGHT, w);
        pls(CM, 8'h00);
        wr(OFF_CTRL_B, 8'h40);
        pls(ZR, 8'h00);
        rdr(OFF_STATUS);
        chk("zc_old_edge", 32'h0, rd[6]);
        pls(ZF, seed[23:16]);
        rdr(OFF_STATUS);
        chk("zc_fall", 32'h1, rd[6]);
        pls(CM, 8'h00);
        wr(OFF_CTRL_A, 8'ha1);
        pls(ZF, 8'h00);
        rdr(OFF_STATUS);
        chk("zc_new_edge", 32'h0, rd[6]);
        pls(ZR, t2);
        st();
        rchk("dly_latest", OFF_DELAY, dly(w, t2));
        wr(OFF_CTRL_A, 8'ha0);
        pls(CM, 8'h00);
        pls(ZR, seed[31:24]);
        st();
        rchk("dly_prev", OFF_DELAY, dly(w, t2));
        // demag masks, sensorless: zero cross only after an accepted demag
        for (int i = 0; i < 2; i++) begin
            wr(OFF_CTRL_A, 8'h80);
            wr(OFF_CTRL_B, 8'h00);
            pls(CM, 8'h00);
            wr(OFF_CTRL_B, i ? 8'h11 : 8'h21);
            pls(i ? SD : HD, 8'h00);
            pls(ZF, 8'h00);
            rdr(OFF_STATUS);
            chk("demag_pend", 32'h0, rd[6]);
            pls(CM, 8'h00);
            pls(i ? SD : HD, 8'h00);
            pls(ZF, 8'h00);
            rdr(OFF_STATUS);
            chk("demag_on", 32'h1, rd[6]);
            // zero-to-commutation span follows the live lowest select bit
            chk("span_side", p & 6'h2a, po);
        end
        for (int t = 0; t < 4; t++) begin
            wr(OFF_CONFIG, 8'(t << 6));
            wr(OFF_CTRL_C, 8'h00);
            pls(OV, 8'h00);
            rdr(OFF_CTRL_C);
            chk("ovf_flag", t == 0, rd[7]);
            wr(OFF_CTRL_C, 8'h00);
            pls(SE, 8'h00);
            rdr(OFF_CTRL_C);
            chk("spd_flag", t != 0, rd[7]);
            wr(OFF_CTRL_C, 8'h00);
            rdr(OFF_CTRL_C);
            chk("c_clear", 32'h0, rd[7]);
        end
        // over-current table: irq enable and voltage handling combinations
        for (int k = 0; k < 3; k++) begin
            current_limit_irq_enable = k > 0;
            voltage_overcurrent_handling = k == 2;
            trip = current_limit_irq_enable & voltage_overcurrent_handling;
            pwm <= seed[k];
            wr(OFF_CTRL_A, 8'h80);
            wr(OFF_CTRL_B, {4'h0, voltage_overcurrent_handling, 3'h0});
            wr(OFF_CONFIG, {7'h0, current_limit_irq_enable});
            pls(CL, 8'h00);
            // enables drop one cycle after the trip clears the enable bit
            st();
            chk("cl_irq", current_limit_irq_enable, irq);
            chk("pwm_cut", !trip, cut);
            chk("cl_oe", trip ? {26'h0, ROE} : 32'h3f, oe);
            rdr(OFF_CTRL_A);
            chk("moe", !trip, rd[7]);
            wr(OFF_STATUS, 8'h00);
            st();
            chk("irq_clr", 32'h0, irq);
            chk("cut_clr", 32'h0, cut);
        end
        chk("shoot", 32'h0, shoot);
        end_sim();
    end
endmodule
`default_nettype wire
